// ---- error_status_and_cal_exit_tb.sv ----
// Testbench: drives fault events and host commands, judges answers.
// Assumes: package, design, host model and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module error_status_and_cal_exit_tb;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [9:0] ev = '0;
    logic [7:0] cal = 8'h00;
    logic [3:0] cmd;
    logic cal_mode, valid, led;
    logic [7:0] flags, code;
    int num_errors = 0;
    int check_count = 0;
    // Flag bit per fault source; last entry is calibration status
    localparam int BT[11] = '{0, 1, 2, 5, 5, 5, 4, 4, 4, 7, 3};
    always #50 ref_clk_in = ~ref_clk_in;
    erscx_host u_host (.ref_clk_in(ref_clk_in), .cal_mode_in(cal_mode), .cmd_out(cmd));
    erscx_top u_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .cmd_enter_cal_in(cmd[0]), .cmd_leave_cal_in(cmd[1]), .cmd_error_query_in(cmd[2]),
        .status_query_clear_command_in(cmd[3]), .bad_syntax_error_in(ev[0]),
        .bad_option_error_in(ev[1]), .channel_config_error_in(ev[2]), .open_input_in(ev[3]),
        .adc_full_scale_in(ev[4]), .linearization_limit_in(ev[5]), .extra_start_in(ev[6]),
        .extra_stop_in(ev[7]), .unexpected_start_in(ev[8]), .command_conflict_in(ev[9]),
        .calibration_status_flags_in(cal), .cal_mode_out(cal_mode),
        .error_source_flags_out(flags), .error_code_valid_out(valid),
        .error_code_out(code), .error_led_out(led));
    // ------
    // Tasks
    // ------
    // Cal status bit 5 is the top bit that must still map to a flag
    task automatic ev_pulse(input int i);
        @(negedge ref_clk_in);
        if (i < 10) ev[i] = 1'b1; else cal = 8'h20;
        @(negedge ref_clk_in);
        ev = '0;
        cal = 8'h00;
    endtask
    task automatic query(input logic [7:0] exp);
        u_host.pulse(2);
        `CHK("valid", 1'b1, valid)
        `CHK("code", exp, code)
        `CHK("flags", 8'h00, flags)
        `CHK("led", 1'b0, led)
    endtask
    task automatic t_each();
        for (int i = 0; i < 11; i++) begin
            ev_pulse(i);
            `CHK("flags", 8'h01 << BT[i], flags)
            `CHK("led", 1'b1, led)
            query(8'h01 << BT[i]);
        end
    endtask
    // Several pending at once: only the top one may be reported
    task automatic t_prio();
        @(negedge ref_clk_in);
        ev = 10'h207;
        @(negedge ref_clk_in);
        ev = '0;
        query(8'h80);
        query(8'h00);
    endtask
    task automatic t_status();
        ev_pulse(6);
        u_host.pulse(3);
        `CHK("flags", 8'h00, flags)
        `CHK("valid", 1'b0, valid)
        `CHK("led", 1'b0, led)
    endtask
    // Fault in the query cycle misses this answer but stays pending
    task automatic t_same();
        ev_pulse(9);
        fork
            u_host.pulse(2);
            ev_pulse(0);
        join
        `CHK("code", 8'h80, code)
        `CHK("flags", 8'h01, flags)
        `CHK("led", 1'b1, led)
        @(negedge ref_clk_in);
        `CHK("valid", 1'b0, valid)
        `CHK("code", 8'h80, code)
        query(8'h01);
    endtask
    // Mid-run reset: all outputs back to zero, nothing false after release
    task automatic t_reset();
        u_host.pulse(0);
        ev_pulse(9);
        @(negedge ref_clk_in);
        reset_n_in = 1'b0;
        @(negedge ref_clk_in);
        `CHK("flags", erscx_pkg::ERR_RESET, flags)
        `CHK("led", 1'b0, led)
        `CHK("cal", 1'b0, cal_mode)
        `CHK("code", erscx_pkg::CODE_NONE, code)
        reset_n_in = 1'b1;
        @(negedge ref_clk_in);
        `CHK("valid", 1'b0, valid)
        `CHK("flags", erscx_pkg::ERR_RESET, flags)
    endtask
    task automatic t_cal();
        u_host.pulse(0);
        `CHK("cal", 1'b1, cal_mode)
        u_host.pulse(1);
        `CHK("cal", 1'b0, cal_mode)
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        `CHK("flags", erscx_pkg::ERR_RESET, flags)
        t_each();
        t_prio();
        t_same();
        t_status();
        t_reset();
        t_cal();
        final_report();
    end
endmodule
bind erscx_top erscx_top_sva u_sva (.*);
`default_nettype wire

// ---- erscx_encode.sv ----
// Priority encoder: highest set error flag to its reported code.
// Assumes: flags come registered from the top module.
`timescale 1ns/10ps
`default_nettype none
module erscx_encode (
    input wire logic [7:0] flags_in,
    output logic [7:0] code_out
);
    // Highest-numbered flag wins; bit 6 carries no code
    always_comb begin
        if (flags_in[erscx_pkg::BIT_CONFLICT]) begin
            code_out = erscx_pkg::CODE_CONFLICT;
        end else if (flags_in[erscx_pkg::BIT_RANGE]) begin
            code_out = erscx_pkg::CODE_RANGE;
        end else if (flags_in[erscx_pkg::BIT_TRIGGER]) begin
            code_out = erscx_pkg::CODE_TRIGGER;
        end else if (flags_in[erscx_pkg::BIT_CAL]) begin
            code_out = erscx_pkg::CODE_CAL;
        end else if (flags_in[erscx_pkg::BIT_CHANNEL]) begin
            code_out = erscx_pkg::CODE_CHANNEL;
        end else if (flags_in[erscx_pkg::BIT_OPTION]) begin
            code_out = erscx_pkg::CODE_OPTION;
        end else if (flags_in[erscx_pkg::BIT_SYNTAX]) begin
            code_out = erscx_pkg::CODE_SYNTAX;
        end else begin
            code_out = erscx_pkg::CODE_NONE;
        end
    end
endmodule
`default_nettype wire

// ---- erscx_flag.sv ----
// One sticky error flag: set by an event, cleared by a query.
// Assumes: set and clear come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module erscx_flag (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag_out
);
    logic flag_r;
    logic flag_nxt;

    // Set wins so an event in the clearing cycle is kept
    always_comb begin
        flag_nxt = flag_r;
        if (clear_in) begin
            flag_nxt = 1'b0;
        end
        if (set_in) begin
            flag_nxt = 1'b1;
        end
    end

    // Flag register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_out = flag_r;
endmodule
`default_nettype wire

// ---- erscx_host.sv ----
// Host model: sends one-cycle command strobes.
// Assumes: the block samples them on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module erscx_host (
    input wire logic ref_clk_in,
    input wire logic cal_mode_in,
    output logic [3:0] cmd_out
);
    initial cmd_out = 4'h0;
    // Bits: enter, leave, query, status clear; idle low between commands
    task automatic pulse(input int k);
        if (k != 1 || cal_mode_in) begin
            @(negedge ref_clk_in) cmd_out[k] = 1'b1;
            @(negedge ref_clk_in) cmd_out = 4'h0;
        end
    endtask
endmodule
`default_nettype wire

// ---- erscx_pkg.sv ----
// Package: constants for the error status and calibration exit block.
// Assumes: included before all design modules of this block.
package erscx_pkg;
    // ------------------------------------------------------------------
    // Error source flag positions
    // ------------------------------------------------------------------
    localparam int ERR_WIDTH = 8;
    localparam int BIT_SYNTAX = 0;
    localparam int BIT_OPTION = 1;
    localparam int BIT_CHANNEL = 2;
    localparam int BIT_CAL = 3;
    localparam int BIT_TRIGGER = 4;
    localparam int BIT_RANGE = 5;
    localparam int BIT_CONFLICT = 7;
    localparam logic [7:0] ERR_RESET = 8'h00;
    // Calibration status error indicator bits 0..5
    localparam int CAL_WIDTH = 8;
    localparam logic [7:0] CAL_ERR_MASK = 8'h3f;
    // ------------------------------------------------------------------
    // Reported codes (decimal value of the code)
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_SYNTAX = 8'h01;
    localparam logic [7:0] CODE_OPTION = 8'h02;
    localparam logic [7:0] CODE_CHANNEL = 8'h04;
    localparam logic [7:0] CODE_CAL = 8'h08;
    localparam logic [7:0] CODE_TRIGGER = 8'h10;
    localparam logic [7:0] CODE_RANGE = 8'h20;
    localparam logic [7:0] CODE_CONFLICT = 8'h80;
endpackage

// ---- erscx_top.sv ----
// Error status query and calibration exit command logic.
// Assumes: a command decoder on ref_clk_in gives one-cycle command
// strobes and one-cycle fault events; calibration flags are same-clock.
//
// Functional notes
// - Leave-calibration ends calibration mode; enter-calibration alone restores it.
// - Error query reports the present condition from the 8-bit flags.
// - Each error query answer is exactly one defined code.
// - Command conflict sets flag bit seven, code E128.
// - Open input, full scale or linearization overflow sets bit five, E032.
// - Extra start or stop, or unexpected start, sets bit four, E016.
// - Any calibration status bit zero to five sets bit three, E008.
// - Missing channel or unsupported channel type sets bit two, E004.
// - Missing or out-of-range parameter sets bit one, E002.
// - Command syntax error sets bit zero, E001.
// - No pending flag answers E000.
// - Front-panel error indicator lights when an error is recorded.
// - Error query clears pending error conditions.
// - Status query-and-clear command also clears error conditions.
// - Indicator stays lit until a query or status clear clears it.
`timescale 1ns/10ps
`default_nettype none
module erscx_top (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic cmd_enter_cal_in,
    input wire logic cmd_leave_cal_in,
    input wire logic cmd_error_query_in,
    input wire logic status_query_clear_command_in,
    input wire logic bad_syntax_error_in,
    input wire logic bad_option_error_in,
    input wire logic channel_config_error_in,
    input wire logic open_input_in,
    input wire logic adc_full_scale_in,
    input wire logic linearization_limit_in,
    input wire logic extra_start_in,
    input wire logic extra_stop_in,
    input wire logic unexpected_start_in,
    input wire logic command_conflict_in,
    input wire logic [7:0] calibration_status_flags_in,
    output logic cal_mode_out,
    output logic [7:0] error_source_flags_out,
    output logic error_code_valid_out,
    output logic [7:0] error_code_out,
    output logic error_led_out
);
    // ------------------------------------------------------------------
    // Calibration mode
    // ------------------------------------------------------------------
    // Two states suffice: the calibration steps themselves live elsewhere
    typedef enum logic [0:0] {
        ERSCX_CAL_OFF = 1'b0,
        ERSCX_CAL_ON = 1'b1
    } erscx_cal_state_e;

    erscx_cal_state_e cal_state_r;
    erscx_cal_state_e cal_state_nxt;

    // Leave beats enter; leave while out of calibration keeps the mode off
    always_comb begin
        cal_state_nxt = cal_state_r;
        case (cal_state_r)
            ERSCX_CAL_OFF: begin
                if (cmd_enter_cal_in && !cmd_leave_cal_in) begin
                    cal_state_nxt = ERSCX_CAL_ON;
                end
            end
            ERSCX_CAL_ON: begin
                if (cmd_leave_cal_in) begin
                    cal_state_nxt = ERSCX_CAL_OFF;
                end
            end
            default: begin
                cal_state_nxt = ERSCX_CAL_OFF;
            end
        endcase
    end

    // Mode register; reset leaves the unit out of calibration
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cal_state_r <= ERSCX_CAL_OFF;
        end else begin
            cal_state_r <= cal_state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Fault events
    // ------------------------------------------------------------------
    logic syntax_event;
    logic option_event;
    logic channel_event;
    logic cal_fault_event;
    logic trigger_event;
    logic range_event;
    logic conflict_event;
    logic clear_all;

    // One event per flag; sources sharing a flag are ORed, any one sets it
    assign syntax_event = bad_syntax_error_in;
    assign option_event = bad_option_error_in;
    assign channel_event = channel_config_error_in;
    assign cal_fault_event =
        |(calibration_status_flags_in & erscx_pkg::CAL_ERR_MASK);
    assign trigger_event =
        extra_start_in | extra_stop_in | unexpected_start_in;
    assign range_event =
        open_input_in | adc_full_scale_in | linearization_limit_in;
    assign conflict_event = command_conflict_in;

    // Either query clears every flag; a fault in the same cycle survives it
    assign clear_all = cmd_error_query_in | status_query_clear_command_in;

    // ------------------------------------------------------------------
    // Error source flags
    // ------------------------------------------------------------------
    logic flag_syntax;
    logic flag_option;
    logic flag_channel;
    logic flag_cal;
    logic flag_trigger;
    logic flag_range;
    logic flag_conflict;
    logic [7:0] flags;

    // Syntax fault
    erscx_flag u_flag_syntax (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(syntax_event),
        .clear_in(clear_all),
        .flag_out(flag_syntax)
    );

    // Missing or out-of-range parameter
    erscx_flag u_flag_option (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(option_event),
        .clear_in(clear_all),
        .flag_out(flag_option)
    );

    // Channel configuration fault
    erscx_flag u_flag_channel (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(channel_event),
        .clear_in(clear_all),
        .flag_out(flag_channel)
    );

    // Calibration fault, from the status flags
    erscx_flag u_flag_cal (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(cal_fault_event),
        .clear_in(clear_all),
        .flag_out(flag_cal)
    );

    // Trigger overrun
    erscx_flag u_flag_trigger (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(trigger_event),
        .clear_in(clear_all),
        .flag_out(flag_trigger)
    );

    // Open input or range fault
    erscx_flag u_flag_range (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(range_event),
        .clear_in(clear_all),
        .flag_out(flag_range)
    );

    // Command conflict
    erscx_flag u_flag_conflict (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .set_in(conflict_event),
        .clear_in(clear_all),
        .flag_out(flag_conflict)
    );

    // Flags on their positions; bit 6 has no source and always reads zero
    always_comb begin
        flags = erscx_pkg::ERR_RESET;
        flags[erscx_pkg::BIT_SYNTAX] = flag_syntax;
        flags[erscx_pkg::BIT_OPTION] = flag_option;
        flags[erscx_pkg::BIT_CHANNEL] = flag_channel;
        flags[erscx_pkg::BIT_CAL] = flag_cal;
        flags[erscx_pkg::BIT_TRIGGER] = flag_trigger;
        flags[erscx_pkg::BIT_RANGE] = flag_range;
        flags[erscx_pkg::BIT_CONFLICT] = flag_conflict;
    end

    // ------------------------------------------------------------------
    // Front-panel error indicator
    // ------------------------------------------------------------------
    logic [7:0] set_vec;
    logic [7:0] flags_after;
    logic led_r;
    logic led_nxt;

    // Fault events on their flag positions
    always_comb begin
        set_vec = erscx_pkg::ERR_RESET;
        set_vec[erscx_pkg::BIT_SYNTAX] = syntax_event;
        set_vec[erscx_pkg::BIT_OPTION] = option_event;
        set_vec[erscx_pkg::BIT_CHANNEL] = channel_event;
        set_vec[erscx_pkg::BIT_CAL] = cal_fault_event;
        set_vec[erscx_pkg::BIT_TRIGGER] = trigger_event;
        set_vec[erscx_pkg::BIT_RANGE] = range_event;
        set_vec[erscx_pkg::BIT_CONFLICT] = conflict_event;
    end

    // Lamp follows the flags' own next values: a set beats a clear, so a
    // fault in the clearing cycle keeps the lamp lit without a blink
    always_comb begin
        flags_after = (flags & ~{erscx_pkg::ERR_WIDTH{clear_all}}) | set_vec;
        led_nxt = |flags_after;
    end

    // Lamp flop; costs one flop but keeps the pin free of decode glitches
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            led_r <= 1'b0;
        end else begin
            led_r <= led_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Error query answer
    // ------------------------------------------------------------------
    // Answer strobe: one cycle in the show state after each query
    typedef enum logic [0:0] {
        ERSCX_ANS_IDLE = 1'b0,
        ERSCX_ANS_SHOW = 1'b1
    } erscx_ans_state_e;

    erscx_ans_state_e ans_state_r;
    erscx_ans_state_e ans_state_nxt;
    logic [7:0] code_now;
    logic [7:0] code_r;
    logic [7:0] code_nxt;

    // Highest pending flag to its code
    erscx_encode u_encode (
        .flags_in(flags),
        .code_out(code_now)
    );

    // Code taken from the flags as they stand at the query edge, before the
    // clear lands; a fault in that same cycle waits for the next query
    always_comb begin
        code_nxt = code_r;
        ans_state_nxt = ERSCX_ANS_IDLE;
        case (ans_state_r)
            ERSCX_ANS_IDLE: begin
                if (cmd_error_query_in) begin
                    ans_state_nxt = ERSCX_ANS_SHOW;
                    code_nxt = code_now;
                end
            end
            ERSCX_ANS_SHOW: begin
                // Back-to-back queries each get a fresh answer
                if (cmd_error_query_in) begin
                    ans_state_nxt = ERSCX_ANS_SHOW;
                    code_nxt = code_now;
                end
            end
            default: begin
                ans_state_nxt = ERSCX_ANS_IDLE;
            end
        endcase
    end

    // Answer registers; the code holds until the next query
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ans_state_r <= ERSCX_ANS_IDLE;
            code_r <= erscx_pkg::CODE_NONE;
        end else begin
            ans_state_r <= ans_state_nxt;
            code_r <= code_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Mode and answer strobe decode straight from their state registers
    assign cal_mode_out = (cal_state_r == ERSCX_CAL_ON);
    assign error_code_valid_out = (ans_state_r == ERSCX_ANS_SHOW);

    // Data outputs come straight from flops
    assign error_source_flags_out = flags;
    assign error_code_out = code_r;
    assign error_led_out = led_r;
endmodule
`default_nettype wire

// ---- erscx_top_sva.sv ----
// Checker: flag, lamp, answer and mode relations of erscx_top.
// Assumes: bound to erscx_top; one clock, async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module erscx_top_sva (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic cmd_leave_cal_in,
    input wire logic cmd_error_query_in,
    input wire logic status_query_clear_command_in,
    input wire logic bad_syntax_error_in,
    input wire logic bad_option_error_in,
    input wire logic channel_config_error_in,
    input wire logic open_input_in,
    input wire logic adc_full_scale_in,
    input wire logic linearization_limit_in,
    input wire logic extra_start_in,
    input wire logic extra_stop_in,
    input wire logic unexpected_start_in,
    input wire logic command_conflict_in,
    input wire logic [7:0] calibration_status_flags_in,
    input wire logic cal_mode_out,
    input wire logic [7:0] error_source_flags_out,
    input wire logic error_code_valid_out,
    input wire logic [7:0] error_code_out,
    input wire logic error_led_out
);
    // ------
    // Properties
    // ------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire rng = open_input_in | adc_full_scale_in | linearization_limit_in;
    wire clr = cmd_error_query_in | status_query_clear_command_in;
    wire trg = extra_start_in | extra_stop_in | unexpected_start_in;
    wire cal_ev = |(calibration_status_flags_in & erscx_pkg::CAL_ERR_MASK);
    wire any_ev = bad_syntax_error_in | bad_option_error_in | channel_config_error_in
        | rng | trg | cal_ev | command_conflict_in;
    property p_syn; bad_syntax_error_in |=> error_source_flags_out[0]; endproperty
    a_syn: assert property (p_syn) else $error("syntax flag missing");
    property p_rng; rng |=> error_source_flags_out[5]; endproperty
    a_rng: assert property (p_rng) else $error("range flag missing");
    property p_cal;
        |(calibration_status_flags_in & erscx_pkg::CAL_ERR_MASK) |=> error_source_flags_out[3];
    endproperty
    a_cal: assert property (p_cal) else $error("cal flag missing");
    property p_conf; command_conflict_in |=> error_source_flags_out[7]; endproperty
    a_conf: assert property (p_conf) else $error("conflict flag missing");
    property p_led; error_led_out == |error_source_flags_out; endproperty
    a_led: assert property (p_led) else $error("lamp differs from flags");
    property p_hold; error_led_out && !clr |=> error_led_out; endproperty
    a_hold: assert property (p_hold) else $error("lamp went out early");
    property p_leave; cmd_leave_cal_in |=> !cal_mode_out; endproperty
    a_leave: assert property (p_leave) else $error("still calibrating");
    property p_vld; error_code_valid_out == $past(cmd_error_query_in); endproperty
    a_vld: assert property (p_vld) else $error("answer strobe wrong");
    property p_trg; trg |=> error_source_flags_out[4]; endproperty
    a_trg: assert property (p_trg) else $error("trigger flag missing");
    property p_chan; channel_config_error_in |=> error_source_flags_out[2]; endproperty
    a_chan: assert property (p_chan) else $error("channel flag missing");
    property p_opt; bad_option_error_in |=> error_source_flags_out[1]; endproperty
    a_opt: assert property (p_opt) else $error("option flag missing");
    property p_clr; clr && !any_ev |=> error_source_flags_out == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared");
    property p_code;
        error_code_valid_out |-> $onehot0(error_code_out) && !error_code_out[6];
    endproperty
    a_code: assert property (p_code) else $error("answer not a defined code");
    c_query: cover property (cmd_error_query_in && error_led_out);
    c_same: cover property (cmd_error_query_in && bad_syntax_error_in);
    c_clear: cover property (status_query_clear_command_in && error_led_out);
    c_leave: cover property (cmd_leave_cal_in && cal_mode_out);
endmodule
`default_nettype wire
